// file: src/ets_params.svh
// Offsets, fields, reset values and timing counts of the one-shot timer
`ifndef ETS_PARAMS_SVH
`define ETS_PARAMS_SVH
// ==========================================
// Register map (byte addresses)
`define ETS_AW 4
`define ETS_OFF_CTRL 4'h0
`define ETS_OFF_PERIOD 4'h4
`define ETS_OFF_PULSE 4'h8
`define ETS_OFF_STATUS 4'hC
// ==========================================
// Fields and widths
`define ETS_CNT_W 8
`define ETS_CTRL_RUN 0
`define ETS_CTRL_MODE_LO 1
`define ETS_CTRL_MODE_HI 5
// ==========================================
// Reset values
`define ETS_RST_MODE 5'h00
`define ETS_RST_PERIOD 8'hFF
`define ETS_RST_PULSE 8'h00
// ==========================================
// Mode codes
`define ETS_MODE_ET_RISE 5'h09
`define ETS_MODE_ET_FALL 5'h0A
`define ETS_MODE_ET_BOTH 5'h0B
`define ETS_MODE_HL_RISE 5'h0C
`define ETS_MODE_HL_FALL 5'h0D
// ==========================================
// Timing: timer clocks from a limit reset edge to resumed counting
`define ETS_RESUME_CLKS 2'h2
// AXI responses
`define ETS_RESP_OKAY 2'h0
`define ETS_RESP_SLVERR 2'h2
`endif

// file: src/ets_pkg.sv
// Types shared by the one-shot timer modules
package ets_pkg;
`include "ets_params.svh"
  // ==========================================
  // Timer states
  typedef enum logic [1:0] {
    ETS_IDLE = 2'b00,
    ETS_ARMED = 2'b01,
    ETS_COUNT = 2'b10,
    ETS_HOLD = 2'b11
  } ets_state_e;
  // Register write strobe with address and data
  typedef struct packed {
    logic en;
    logic [`ETS_AW-1:0] addr;
    logic [31:0] data;
  } ets_wr_s;
  // Mapped, word-aligned addresses only
  function automatic logic ets_addr_ok(input logic [`ETS_AW-1:0] a);
    return (a == `ETS_OFF_CTRL) || (a == `ETS_OFF_PERIOD) || (a == `ETS_OFF_PULSE) || (a == `ETS_OFF_STATUS);
  endfunction
endpackage

// file: src/ets_sync.sv
// Two-flop synchroniser for the external trigger pin
module ets_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta;
  // ==========================================
  // First flop feeds only the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// file: src/ets_axil.sv
// AXI4-Lite slave front end for the one-shot timer registers
`include "ets_params.svh"
module ets_axil (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [3:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output ets_pkg::ets_wr_s wr_o,
  output logic [3:0] rd_addr_o,
  input wire logic [31:0] rd_data_i
);
  import ets_pkg::*;
  logic aw_hold, w_hold, next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
  logic [3:0] waddr, next_waddr;
  logic [31:0] wdata, next_wdata, next_rdata;
  logic wlow, next_wlow;
  logic [1:0] next_bresp, next_rresp;
  logic do_wr;

  // ==========================================
  // Handshakes; address and data may arrive in either order
  assign awready_o = !aw_hold && !bvalid_o;
  assign wready_o = !w_hold && !bvalid_o;
  assign arready_o = !rvalid_o;
  assign rd_addr_o = araddr_i;
  assign do_wr = aw_hold && w_hold && !bvalid_o;
  // Only byte lane 0 holds register bits, so it gates the write
  assign wr_o = '{en: do_wr && wlow && ets_addr_ok(waddr), addr: waddr, data: wdata};

  // Next channel state
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_waddr = waddr;
    next_wdata = wdata;
    next_wlow = wlow;
    next_bvalid = bvalid_o;
    next_bresp = bresp_o;
    next_rvalid = rvalid_o;
    next_rdata = rdata_o;
    next_rresp = rresp_o;
    if (awvalid_i && awready_o) begin
      next_aw_hold = 1'b1;
      next_waddr = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      next_w_hold = 1'b1;
      next_wdata = wdata_i;
      next_wlow = wstrb_i[0];
    end
    if (do_wr) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = ets_addr_ok(waddr) ? `ETS_RESP_OKAY : `ETS_RESP_SLVERR;
    end else if (bvalid_o && bready_i) begin
      next_bvalid = 1'b0;
    end
    if (arvalid_i && arready_o) begin
      next_rvalid = 1'b1;
      next_rdata = rd_data_i;
      next_rresp = ets_addr_ok(araddr_i) ? `ETS_RESP_OKAY : `ETS_RESP_SLVERR;
    end else if (rvalid_o && rready_i) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      waddr <= 4'h0;
      wdata <= 32'h0000_0000;
      wlow <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= 2'h0;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= 2'h0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wlow <= next_wlow;
      bvalid_o <= next_bvalid;
      bresp_o <= next_bresp;
      rvalid_o <= next_rvalid;
      rdata_o <= next_rdata;
      rresp_o <= next_rresp;
    end
  end
endmodule

// file: src/ets_timer.sv
// Edge-triggered one-shot period timer with PWM drive, top level
// Contract
// - One-shot mode waits idle after run set until the selected trigger edge.
// - Start edge codes: 01001 rising, 01010 falling, 01011 either edge.
// - One-shot period match clears the run bit, halting the timer.
// - After software stops and restarts, a fresh trigger edge is needed.
// - Trigger edge turns PWM on; pulse match or period halt turns it off.
// - Limit mode: first edge starts; later selected edges reset the counter.
// - Limit mode resumes counting two timer clocks after each reset edge.
// - Limit codes: 01100 rising start/reset, 01101 falling start/reset.
// - Limit mode period match resets the counter and clears run.
// - Limit mode ignores all edges until software sets run.
// - Limit mode: start edge and each reset edge turn PWM drive on.
// - PWM stays off after pulse match unless an edge resets first.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`include "ets_params.svh"
module ets_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic external_trigger_input_i,
  output logic pwm_drive_o,
  output logic timer_run_o
);
  import ets_pkg::*;

  ets_wr_s wr;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  logic trig_s, trig_q;
  logic rise, fall, trig_fire, is_et, is_hl, is_os;
  logic ctrl_wr;
  logic run, next_run, pwm, next_pwm;
  logic [4:0] mode, next_mode;
  logic [`ETS_CNT_W-1:0] cnt, next_cnt, period, next_period, pulse, next_pulse;
  logic [1:0] hold, next_hold;
  ets_state_e st, next_st;

  // ==========================================
  // Bus slave and trigger synchroniser
  ets_axil u_axil (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .awaddr_i(s_axi_awaddr_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .bresp_o(s_axi_bresp_o),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .araddr_i(s_axi_araddr_i),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .wr_o(wr),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data)
  );

  // Pin crosses two flops before any logic reads it
  ets_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(external_trigger_input_i),
    .q_o(trig_s)
  );

  // ==========================================
  // Edge detection and mode decode
  assign rise = trig_s && !trig_q;
  assign fall = !trig_s && trig_q;
  assign is_et = (mode == `ETS_MODE_ET_RISE) || (mode == `ETS_MODE_ET_FALL) || (mode == `ETS_MODE_ET_BOTH);
  assign is_hl = (mode == `ETS_MODE_HL_RISE) || (mode == `ETS_MODE_HL_FALL);
  assign is_os = is_et || is_hl;
  assign ctrl_wr = wr.en && (wr.addr == `ETS_OFF_CTRL);
  assign pwm_drive_o = pwm;
  assign timer_run_o = run;

  // Selected edge per mode; other codes have no trigger
  always_comb begin
    case (mode)
      `ETS_MODE_ET_RISE: trig_fire = rise;
      `ETS_MODE_ET_FALL: trig_fire = fall;
      `ETS_MODE_ET_BOTH: trig_fire = rise || fall;
      `ETS_MODE_HL_RISE: trig_fire = rise;
      `ETS_MODE_HL_FALL: trig_fire = fall;
      default: trig_fire = 1'b0;
    endcase
  end

  // ==========================================
  // Timer next state, software write applied last
  always_comb begin
    next_run = run;
    next_mode = mode;
    next_st = st;
    next_cnt = cnt;
    next_pwm = pwm;
    next_hold = hold;
    next_period = period;
    next_pulse = pulse;
    case (st)
      ETS_ARMED: begin
        // Edges before run is set never reach here
        if (trig_fire) begin
          next_st = ETS_COUNT;
          next_pwm = 1'b1;
        end
      end
      ETS_COUNT: begin
        if (is_hl && trig_fire) begin
          next_cnt = '0;
          next_hold = `ETS_RESUME_CLKS - 2'h1;
          next_st = ETS_HOLD;
          next_pwm = 1'b1;
        end else if (cnt == period) begin
          next_cnt = '0;
          next_pwm = !is_os;
          if (is_os) begin
            next_run = 1'b0;
            next_st = ETS_IDLE;
          end
        end else begin
          next_cnt = cnt + 8'h01;
          if (cnt == pulse) begin
            next_pwm = 1'b0;
          end
        end
      end
      ETS_HOLD: begin
        // A further edge during the pause restarts the pause
        if (trig_fire) begin
          next_hold = `ETS_RESUME_CLKS - 2'h1;
        end else if (hold == 2'h0) begin
          next_st = ETS_COUNT;
        end else begin
          next_hold = hold - 2'h1;
        end
      end
      default: ;
    endcase
    // Software set of run wins over a same-cycle halt
    if (ctrl_wr) begin
      next_mode = wr.data[`ETS_CTRL_MODE_HI:`ETS_CTRL_MODE_LO];
      if (!wr.data[`ETS_CTRL_RUN]) begin
        next_run = 1'b0;
        next_st = ETS_IDLE;
        next_pwm = 1'b0;
      end else if (!next_run) begin
        next_run = 1'b1;
        next_pwm = 1'b0;
        if ((wr.data[5:1] >= `ETS_MODE_ET_RISE) && (wr.data[5:1] <= `ETS_MODE_HL_FALL)) begin
          next_st = ETS_ARMED;
        end else begin
          next_st = ETS_COUNT;
        end
      end
    end
    if (wr.en && (wr.addr == `ETS_OFF_PERIOD)) begin
      next_period = wr.data[7:0];
    end
    if (wr.en && (wr.addr == `ETS_OFF_PULSE)) begin
      next_pulse = wr.data[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run <= 1'b0;
      mode <= `ETS_RST_MODE;
      st <= ETS_IDLE;
      cnt <= '0;
      pwm <= 1'b0;
      hold <= 2'h0;
      period <= `ETS_RST_PERIOD;
      pulse <= `ETS_RST_PULSE;
      trig_q <= 1'b0;
    end else begin
      run <= next_run;
      mode <= next_mode;
      st <= next_st;
      cnt <= next_cnt;
      pwm <= next_pwm;
      hold <= next_hold;
      period <= next_period;
      pulse <= next_pulse;
      trig_q <= trig_s;
    end
  end

  // ==========================================
  // Register read mux; unmapped reads return zero
  always_comb begin
    case (rd_addr)
      `ETS_OFF_CTRL: rd_data = {26'h000_0000, mode, run};
      `ETS_OFF_PERIOD: rd_data = {24'h00_0000, period};
      `ETS_OFF_PULSE: rd_data = {24'h00_0000, pulse};
      `ETS_OFF_STATUS: rd_data = {21'h00_0000, st, pwm, cnt};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // ==========================================
  // Assertions
  property p_armed_still;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_ARMED && !trig_fire && !ctrl_wr) |=> (st == ETS_ARMED && cnt == $past(cnt));
  endproperty
  a_armed_still: assert property (p_armed_still) else $error("armed timer moved without edge");

  property p_fall_start;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_ARMED && mode == `ETS_MODE_ET_FALL && fall && !ctrl_wr) |=> (st == ETS_COUNT && pwm);
  endproperty
  a_fall_start: assert property (p_fall_start) else $error("falling edge did not start timer");

  property p_et_halt;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_COUNT && is_et && cnt == period && !ctrl_wr) |=> (!run && st == ETS_IDLE && !pwm);
  endproperty
  a_et_halt: assert property (p_et_halt) else $error("period match did not halt one-shot");

  property p_rearm;
    @(posedge clk_i) disable iff (!rst_n_i)
    ($rose(run) && is_os) |-> (st == ETS_ARMED);
  endproperty
  a_rearm: assert property (p_rearm) else $error("run set without re-arming");

  property p_resume;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_COUNT && is_hl && trig_fire && !ctrl_wr) |=> (st == ETS_HOLD && cnt == 8'h00 && pwm) ##1
      (st == ETS_HOLD || !run);
  endproperty
  a_resume: assert property (p_resume) else $error("limit reset edge pause wrong");

  property p_hl_halt;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_COUNT && is_hl && !trig_fire && cnt == period && !ctrl_wr) |=> (cnt == 8'h00 && !run);
  endproperty
  a_hl_halt: assert property (p_hl_halt) else $error("limit period match did not reset");

  property p_idle_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    !run |-> (st == ETS_IDLE && !pwm);
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("timer active with run clear");

  property p_pulse_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_COUNT && cnt == pulse && cnt != period && !(is_hl && trig_fire) && !ctrl_wr) |=> !pwm;
  endproperty
  a_pulse_off: assert property (p_pulse_off) else $error("pwm not off at pulse match");

  property p_count_up;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_COUNT && cnt != period && !(is_hl && trig_fire) && !ctrl_wr) |=> (cnt == $past(cnt) + 8'h01);
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not increment");

  property p_start_on;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_ARMED && trig_fire && !ctrl_wr) |=> (st == ETS_COUNT && pwm && cnt == $past(cnt));
  endproperty
  a_start_on: assert property (p_start_on) else $error("start edge did not turn drive on");

  property p_hold_exit;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_HOLD && hold == 2'h0 && !trig_fire && !ctrl_wr) |=> (st == ETS_COUNT && cnt == 8'h00);
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("limit pause did not end after two clocks");

  property p_hl_rise_start;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_ARMED && mode == `ETS_MODE_HL_RISE && rise && !ctrl_wr) |=> (st == ETS_COUNT && pwm);
  endproperty
  a_hl_rise_start: assert property (p_hl_rise_start) else $error("rising limit edge did not start");

  property p_idle_still;
    @(posedge clk_i) disable iff (!rst_n_i)
    (st == ETS_IDLE && !ctrl_wr) |=> (st == ETS_IDLE && !run && cnt == $past(cnt));
  endproperty
  a_idle_still: assert property (p_idle_still) else $error("stopped timer reacted to an edge");
endmodule

// file: testbench/ets_trig_src.sv
// Behavioural source on the external trigger pin of the one-shot timer
module ets_trig_src (
  input wire logic clk_i,
  output logic trig_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Pin driver
  // Pin idles low until a scenario moves it
  initial begin
    trig_o = 1'b0;
  end
  // Level moves just after a rising edge; the task then waits hold more rising edges, which may be none
  task automatic drive(input logic v, input int hold);
    @(posedge clk_i);
    trig_o <= v;
    repeat (hold) @(posedge clk_i);
  endtask
endmodule

// file: testbench/test_ets_timer.sv
// Self-checking bench for the edge-triggered one-shot timer
`include "ets_params.svh"
module test_ets_timer;
  timeunit 1ns;
  timeprecision 1ns;
  import ets_pkg::*;
  `define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t %s", $time, m); end end
  // ==========================================
  // Signals
  localparam logic [7:0] PER = 8'h1E;
  localparam logic [7:0] PLS = 8'h04;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pwm, run, trig;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int check_count = 0;
  // Clock at 10 MHz
  always #50 clk_i = ~clk_i;
  ets_timer i_ets_timer (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .external_trigger_input_i(trig), .pwm_drive_o(pwm), .timer_run_o(run)
  );
  ets_trig_src i_ets_trig_src (.clk_i(clk_i), .trig_o(trig));
  // ==========================================
  // Common tasks
  task automatic end_of_test;
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Ready is looked at mid-cycle, so the handshake edge is the next rising edge
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic aw_t, w_t;
    int n;
    aw_t = 1'b0;
    w_t = 1'b0;
    n = 0;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_t && w_t) && n < 50) begin
      @(negedge clk_i);
      aw_t = aw_t || (awvalid && awready === 1'b1);
      w_t = w_t || (wvalid && wready === 1'b1);
      @(posedge clk_i);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
    end
    while (n < 50 && bvalid !== 1'b1) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(bvalid, 1'b1, "write answer missing")
    `CHK(bresp, `ETS_RESP_OKAY, "write response")
    @(posedge clk_i);
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic at;
    int n;
    n = 0;
    at = 1'b0;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!at && n < 50) begin
      @(negedge clk_i);
      at = arready === 1'b1;
      @(posedge clk_i);
      n++;
    end
    arvalid <= 1'b0;
    while (n < 50 && rvalid !== 1'b1) begin
      @(negedge clk_i);
      n++;
    end
    `CHK(rvalid, 1'b1, "read answer missing")
    d = rdata;
    r = rresp;
    @(posedge clk_i);
    rready <= 1'b0;
  endtask
  // Bounded wait for the drive output to reach a level
  task automatic wait_pwm(input logic v, input int lim, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < lim && !ok; i++) begin
      @(negedge clk_i);
      ok = pwm === v;
    end
  endtask
  // Counts running cycles and drive cycles until the run bit drops
  task automatic trace(output int hi, output int tot);
    hi = 0;
    tot = 0;
    while (run === 1'b1 && tot < 300) begin
      hi += (pwm === 1'b1);
      tot++;
      @(negedge clk_i);
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    `CHK(run, 1'b0, "run set after reset")
    axr(4'h2, d, r);
    `CHK(r, `ETS_RESP_SLVERR, "unmapped read response")
    `CHK(d, 32'h0000_0000, "unmapped read data")
    axw(`ETS_OFF_PERIOD, {24'h00_0000, PER});
    axw(`ETS_OFF_PULSE, {24'h00_0000, PLS});
    axr(`ETS_OFF_PERIOD, d, r);
    `CHK(d, {24'h00_0000, PER}, "period readback")
  endtask
  // First edge of the wrong direction is ignored when first_starts is low
  task automatic et_case(input logic [4:0] mode, input logic init, input logic first_starts);
    logic ok;
    int hi, tot;
    axw(`ETS_OFF_CTRL, 32'h0000_0000);
    i_ets_trig_src.drive(init, 4);
    axw(`ETS_OFF_CTRL, 32'({mode, 1'b1}));
    repeat (6) @(negedge clk_i);
    `CHK(pwm, 1'b0, "drive before trigger edge")
    if (!first_starts) begin
      i_ets_trig_src.drive(!init, 0);
      wait_pwm(1'b1, 8, ok);
      `CHK(ok, 1'b0, "wrong edge started timer")
    end
    i_ets_trig_src.drive(init ^ first_starts, 0);
    wait_pwm(1'b1, 10, ok);
    `CHK(ok, 1'b1, "edge did not start timer")
    trace(hi, tot);
    `CHK(tot, PER + 1, "one-shot length")
    `CHK(hi, PLS + 1, "drive width")
    `CHK(pwm, 1'b0, "drive after halt")
  endtask
  task automatic t_restart;
    logic [31:0] d1, d2;
    logic [1:0] r;
    logic ok;
    int hi, tot;
    axw(`ETS_OFF_CTRL, 32'h0000_0000);
    i_ets_trig_src.drive(1'b0, 4);
    axw(`ETS_OFF_CTRL, 32'({`ETS_MODE_ET_RISE, 1'b1}));
    i_ets_trig_src.drive(1'b1, 0);
    wait_pwm(1'b1, 10, ok);
    `CHK(ok, 1'b1, "first start edge missed")
    axw(`ETS_OFF_CTRL, 32'h0000_0000);
    axw(`ETS_OFF_CTRL, 32'({`ETS_MODE_ET_RISE, 1'b1}));
    axr(`ETS_OFF_STATUS, d1, r);
    repeat (8) @(negedge clk_i);
    axr(`ETS_OFF_STATUS, d2, r);
    `CHK(d2[7:0], d1[7:0], "counting without fresh edge")
    `CHK(d2[10:9], 2'h1, "not waiting for edge")
    i_ets_trig_src.drive(1'b0, 4);
    i_ets_trig_src.drive(1'b1, 0);
    wait_pwm(1'b1, 10, ok);
    `CHK(ok, 1'b1, "fresh edge did not resume")
    trace(hi, tot);
    // Counting resumes from the value held at the stop, not from zero
    `CHK(tot, PER + 1 - d1[7:0], "restart length")
  endtask
  // Hardware-limit run with one reset edge after the pulse match
  task automatic t_limit(input logic [4:0] mode, input logic lvl);
    logic [31:0] d;
    logic [1:0] r;
    logic ok;
    int hi, tot;
    axw(`ETS_OFF_CTRL, 32'h0000_0000);
    i_ets_trig_src.drive(!lvl, 4);
    axw(`ETS_OFF_CTRL, 32'({mode, 1'b0}));
    i_ets_trig_src.drive(lvl, 6);
    @(negedge clk_i);
    `CHK(pwm, 1'b0, "edge acted on with run clear")
    `CHK(run, 1'b0, "run set by edge")
    i_ets_trig_src.drive(!lvl, 4);
    axw(`ETS_OFF_CTRL, 32'({mode, 1'b1}));
    i_ets_trig_src.drive(lvl, 0);
    wait_pwm(1'b1, 10, ok);
    `CHK(ok, 1'b1, "start edge missed")
    wait_pwm(1'b0, 20, ok);
    `CHK(ok, 1'b1, "drive not cleared by pulse match")
    i_ets_trig_src.drive(!lvl, 4);
    @(negedge clk_i);
    `CHK(pwm, 1'b0, "drive back on before reset edge")
    i_ets_trig_src.drive(lvl, 0);
    wait_pwm(1'b1, 10, ok);
    `CHK(ok, 1'b1, "reset edge did not reassert drive")
    trace(hi, tot);
    `CHK(tot, PER + 3, "resume delay after reset edge")
    `CHK(hi, PLS + 3, "drive width after reset edge")
    axr(`ETS_OFF_STATUS, d, r);
    `CHK(d[7:0], 8'h00, "counter not reset at period match")
  endtask
  // Free-running code: counter wraps at the period and run stays set
  task automatic t_free;
    logic [31:0] d;
    logic [1:0] r;
    axw(`ETS_OFF_CTRL, 32'h0000_0001);
    repeat (2 * PER) @(negedge clk_i);
    axr(`ETS_OFF_STATUS, d, r);
    `CHK(run, 1'b1, "free-running timer halted")
    `CHK(d[10:9], 2'h2, "free-running timer not counting")
    `CHK(d[7:0] <= PER, 1'b1, "counter passed the period")
    axw(`ETS_OFF_CTRL, 32'h0000_0000);
    `CHK(run, 1'b0, "run not cleared by software")
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    et_case(`ETS_MODE_ET_RISE, 1'b1, 1'b0);
    et_case(`ETS_MODE_ET_FALL, 1'b0, 1'b0);
    et_case(`ETS_MODE_ET_BOTH, 1'b1, 1'b1);
    et_case(`ETS_MODE_ET_BOTH, 1'b0, 1'b1);
    t_restart();
    t_limit(`ETS_MODE_HL_RISE, 1'b1);
    t_limit(`ETS_MODE_HL_FALL, 1'b0);
    t_free();
    end_of_test();
  end
  // Whole run is well under two thousand cycles; five times that means a hang
  initial begin
    #1_000_000;
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
endmodule
